// ### asram_ctl_map.svh
// Purpose: Constants for the asynchronous one-bit memory controller.
// Assumes: 200 MHz clock, fastest speed grade timing.
// Notes: Times in ns; cycle counts derived from the clock period.
// Operation
// - A write runs from the later falling to the earlier rising control.
// - Address is valid no later than the select falling edge in a read.
// - Strobe low at least 6 ns; select and address valid 7 ns before end.
// - Write data set up 5 ns, held 1 ns; address may change 0 ns after.
// - Select is high before supply drops in retention, zero delay.
// - Contents kept at 2 V with select high; wait read cycle after recovery.
`ifndef ASRAM_CTL_MAP_SVH
`define ASRAM_CTL_MAP_SVH
`define ASRAM_CLK_PERIOD_NS 5
`define ASRAM_ADDR_W 16
`define ASRAM_READ_CYCLE_TIME_NS 9
`define ASRAM_ADDRESS_ACCESS_TIME_NS 9
`define ASRAM_OUTPUT_HOLD_TIME_NS 3
`define ASRAM_WRITE_PULSE_WIDTH_NS 6
`define ASRAM_SELECT_TO_WRITE_END_NS 7
`define ASRAM_WRITE_DATA_SETUP_NS 5
`define ASRAM_WRITE_DATA_HOLD_NS 1
`define ASRAM_DESELECT_TO_OUTPUT_FLOAT_NS 5
`define ASRAM_RETENTION_RECOVERY_NS 9
// Flip-flop stages between the read pin and the sequencer
`define ASRAM_SYNC_STAGES 2
// Least times round up to whole cycles
`define ASRAM_CEIL_CYC(ns) (((ns) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_RD_CYC `ASRAM_CEIL_CYC(`ASRAM_ADDRESS_ACCESS_TIME_NS)
`define ASRAM_WP_CYC `ASRAM_CEIL_CYC(`ASRAM_SELECT_TO_WRITE_END_NS)
`define ASRAM_DH_CYC `ASRAM_CEIL_CYC(`ASRAM_WRITE_DATA_HOLD_NS)
`define ASRAM_FLOAT_CYC `ASRAM_CEIL_CYC(`ASRAM_DESELECT_TO_OUTPUT_FLOAT_NS)
`define ASRAM_REC_CYC `ASRAM_CEIL_CYC(`ASRAM_RETENTION_RECOVERY_NS)
`endif

// ### asram_pkg.sv
// Purpose: Types for the asynchronous one-bit memory controller.
// Assumes: Constants come from asram_ctl_map.svh.
// Notes: Gray codes in listing order: idle, read, write, hold, gap, retention, recovery.
`default_nettype none
package asram_pkg;
  typedef enum logic [2:0] {
    ASRAM_IDLE = 3'h0,
    ASRAM_RD = 3'h1,
    ASRAM_WR = 3'h3,
    ASRAM_WHOLD = 3'h2,
    ASRAM_GAP = 3'h6,
    ASRAM_RET = 3'h7,
    ASRAM_RECOV = 3'h5
  } asram_state_t;

  typedef struct packed {
    asram_state_t st;
    logic [3:0] cnt;
    logic [15:0] addr;
    logic wdata;
    logic sel_n;
    logic wstb_n;
    logic rdata;
    logic rvalid;
    logic done;
  } asram_regs_t;
endpackage : asram_pkg
`default_nettype wire

// ### asram_ctl.sv
// Purpose: Host-side controller that drives a 64K x 1 asynchronous memory.
// Assumes: Single 200 MHz clock; memory read pin arrives asynchronously.
// Notes: Strobe-controlled writes; read data sampled after two-flop sync.
`timescale 1ns/1ps
`include "asram_ctl_map.svh"
`default_nettype none
module asram_ctl #(
  parameter int ADDR_W = `ASRAM_ADDR_W
) (
  input wire logic clock_i, // System clock
  input wire logic srst_i, // Synchronous reset, high
  input wire logic req_i, // Access request, level
  input wire logic we_i, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] addr_i, // Word address
  input wire logic wdata_i, // Write bit
  input wire logic retain_i, // Ask for low-supply retention
  output logic ready_o, // Request accepted this cycle
  output logic rvalid_o, // Read bit valid, one cycle
  output logic rdata_o, // Read bit
  output logic done_o, // Access finished, one cycle
  output logic retained_o, // Select held high, supply may drop
  output logic [ADDR_W-1:0] mem_addr_o, // Memory address pins
  output logic mem_din_o, // Memory write data pin
  output logic mem_sel_n_o, // Memory chip select, low active
  output logic mem_wstb_n_o, // Memory write strobe, low active
  input wire logic mem_dout_i // Memory read data pin
);
  // Read wait adds the synchroniser stages so the sampled bit has settled
  localparam logic [3:0] RD_C = 4'(`ASRAM_RD_CYC + `ASRAM_SYNC_STAGES);
  localparam logic [3:0] WP_C = 4'(`ASRAM_WP_CYC);
  localparam logic [3:0] DH_C = 4'(`ASRAM_DH_CYC);
  localparam logic [3:0] GAP_C = 4'(`ASRAM_FLOAT_CYC);
  localparam logic [3:0] REC_C = 4'(`ASRAM_REC_CYC);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The address register is fixed at the memory's 16 address pins
  if (ADDR_W != `ASRAM_ADDR_W) begin : g_bad_addr_w
    $error("asram_ctl: ADDR_W must equal the 16-bit memory address");
  end
  // The read wait must fit the 4-bit step counter; the other waits must last at least one cycle
  if (`ASRAM_RD_CYC + `ASRAM_SYNC_STAGES > 15) begin : g_bad_rd_wait
    $error("asram_ctl: read wait does not fit the step counter");
  end
  if (`ASRAM_WP_CYC < 1 || `ASRAM_DH_CYC < 1) begin : g_bad_wr_wait
    $error("asram_ctl: write waits need at least one cycle");
  end
  if (`ASRAM_FLOAT_CYC < 1 || `ASRAM_REC_CYC < 1) begin : g_bad_gap_wait
    $error("asram_ctl: gap and recovery waits need at least one cycle");
  end

  // ----------------------------------------
  // Read pin synchroniser
  // ----------------------------------------
  logic dout_s1_r;
  logic dout_s2_r;
  // Only the second stage feeds the sequencer; the first may be metastable
  always_ff @(posedge clock_i) begin
    dout_s1_r <= mem_dout_i;
    dout_s2_r <= dout_s1_r;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  asram_pkg::asram_regs_t q_r;
  asram_pkg::asram_regs_t q_nxt;
  logic take;
  assign take = (q_r.st == asram_pkg::ASRAM_IDLE) && req_i && !retain_i;
  always_comb begin
    q_nxt = q_r;
    q_nxt.rvalid = 1'b0;
    q_nxt.done = 1'b0;
    unique case (q_r.st)
      asram_pkg::ASRAM_IDLE: begin
        if (retain_i) begin
          q_nxt.st = asram_pkg::ASRAM_RET;
        end else if (req_i) begin
          // Address is set together with select, never after it
          q_nxt.addr = 16'(addr_i);
          q_nxt.wdata = wdata_i;
          q_nxt.sel_n = 1'b0;
          q_nxt.cnt = we_i ? WP_C : RD_C;
          q_nxt.wstb_n = !we_i;
          q_nxt.st = we_i ? asram_pkg::ASRAM_WR : asram_pkg::ASRAM_RD;
        end
      end
      asram_pkg::ASRAM_RD: begin
        // Extra two cycles cover the synchroniser delay
        if (q_r.cnt == 4'h1) begin
          q_nxt.rdata = dout_s2_r;
          q_nxt.rvalid = 1'b1;
          q_nxt.done = 1'b1;
          q_nxt.sel_n = 1'b1;
          q_nxt.cnt = GAP_C;
          q_nxt.st = asram_pkg::ASRAM_GAP;
        end else begin
          q_nxt.cnt = q_r.cnt - 4'h1;
        end
      end
      asram_pkg::ASRAM_WR: begin
        if (q_r.cnt == 4'h1) begin
          q_nxt.wstb_n = 1'b1;
          q_nxt.cnt = DH_C;
          q_nxt.st = asram_pkg::ASRAM_WHOLD;
        end else begin
          q_nxt.cnt = q_r.cnt - 4'h1;
        end
      end
      asram_pkg::ASRAM_WHOLD: begin
        // Data and address held one cycle past the strobe rising
        if (q_r.cnt == 4'h1) begin
          q_nxt.sel_n = 1'b1;
          q_nxt.done = 1'b1;
          q_nxt.cnt = GAP_C;
          q_nxt.st = asram_pkg::ASRAM_GAP;
        end else begin
          q_nxt.cnt = q_r.cnt - 4'h1;
        end
      end
      asram_pkg::ASRAM_GAP: begin
        // Lets the device float its output before the next select
        if (q_r.cnt == 4'h1) begin
          q_nxt.st = asram_pkg::ASRAM_IDLE;
        end else begin
          q_nxt.cnt = q_r.cnt - 4'h1;
        end
      end
      asram_pkg::ASRAM_RET: begin
        if (!retain_i) begin
          q_nxt.cnt = REC_C;
          q_nxt.st = asram_pkg::ASRAM_RECOV;
        end
      end
      asram_pkg::ASRAM_RECOV: begin
        if (q_r.cnt == 4'h1) begin
          q_nxt.st = asram_pkg::ASRAM_IDLE;
        end else begin
          q_nxt.cnt = q_r.cnt - 4'h1;
        end
      end
      default: begin
        q_nxt.st = asram_pkg::ASRAM_IDLE;
        q_nxt.sel_n = 1'b1;
        q_nxt.wstb_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q_r <= '{st: asram_pkg::ASRAM_IDLE, cnt: 4'h0, addr: 16'h0000, wdata: 1'b0,
               sel_n: 1'b1, wstb_n: 1'b1, rdata: 1'b0, rvalid: 1'b0, done: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Combinational so a request is taken in its first idle cycle
  assign ready_o = take;
  assign rvalid_o = q_r.rvalid;
  assign rdata_o = q_r.rdata;
  assign done_o = q_r.done;
  assign retained_o = (q_r.st == asram_pkg::ASRAM_RET);
  assign mem_addr_o = q_r.addr;
  assign mem_din_o = q_r.wdata;
  assign mem_sel_n_o = q_r.sel_n;
  assign mem_wstb_n_o = q_r.wstb_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Pins are registered, so each check sees them one edge after the step that set them
  chk_write_pulse_len: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(mem_wstb_n_o) |-> !mem_wstb_n_o [*2] ##1 !mem_sel_n_o)
    else $error("write strobe pulse too short");
  chk_strobe_inside_sel: assert property (@(posedge clock_i) disable iff (srst_i)
    !mem_wstb_n_o |-> !mem_sel_n_o)
    else $error("strobe low while deselected");
  chk_addr_stable_sel: assert property (@(posedge clock_i) disable iff (srst_i)
    !mem_sel_n_o && !$rose(mem_sel_n_o) && !$fell(mem_sel_n_o) |-> $stable(mem_addr_o))
    else $error("address moved during access");
  chk_data_hold: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(mem_wstb_n_o) |-> $stable(mem_din_o) && $stable(mem_addr_o) && !mem_sel_n_o)
    else $error("write data not held");
  chk_read_spacing: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(mem_sel_n_o) && mem_wstb_n_o |-> !mem_sel_n_o [*4] ##1 rvalid_o)
    else $error("read sampled too early");
  chk_float_gap: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(mem_sel_n_o) |-> mem_sel_n_o [*2])
    else $error("reselected before float");
  chk_retain_sel_high: assert property (@(posedge clock_i) disable iff (srst_i)
    retained_o |-> mem_sel_n_o && mem_wstb_n_o)
    else $error("select low in retention");
  chk_recovery_wait: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(retained_o) |-> mem_sel_n_o [*2])
    else $error("access before recovery");
  chk_take_selects: assert property (@(posedge clock_i) disable iff (srst_i)
    ready_o |=> !mem_sel_n_o && (mem_addr_o == $past(addr_i)))
    else $error("address not presented with select");
  chk_write_starts: assert property (@(posedge clock_i) disable iff (srst_i)
    ready_o && we_i |=> !mem_wstb_n_o && (mem_din_o == $past(wdata_i)))
    else $error("write not started on take");
  chk_read_no_strobe: assert property (@(posedge clock_i) disable iff (srst_i)
    ready_o && !we_i |=> mem_wstb_n_o [*4])
    else $error("strobe low during a read");
  chk_done_deselects: assert property (@(posedge clock_i) disable iff (srst_i)
    done_o |=> !done_o && mem_sel_n_o)
    else $error("access not closed after done");
  chk_sel_after_take: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(mem_sel_n_o) |-> $past(ready_o))
    else $error("select fell without a taken request");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cov_read: cover property (@(posedge clock_i) disable iff (srst_i) rvalid_o);
  cov_write: cover property (@(posedge clock_i) disable iff (srst_i) $rose(mem_wstb_n_o));
  cov_retain: cover property (@(posedge clock_i) disable iff (srst_i) $fell(retained_o));
  cov_back_to_back: cover property (@(posedge clock_i) disable iff (srst_i)
    done_o ##[1:3] ready_o);
  cov_refused: cover property (@(posedge clock_i) disable iff (srst_i) req_i && retained_o);
endmodule : asram_ctl
`default_nettype wire

// ### asram_mem_model.sv
// Purpose: Behavioural 64K x 1 asynchronous memory facing the controller.
// Assumes: Fastest grade pin timing; no pull on the read pin.
// Notes: A floated read pin shows the inverted last bit, never a held value.
`timescale 1ns/1ps
`default_nettype none
module asram_mem_model (
  input wire logic [15:0] addr_i, // Address pins
  input wire logic din_i, // Write data pin
  input wire logic sel_n_i, // Chip select, low active
  input wire logic wstb_n_i, // Write strobe, low active
  input wire logic slow_i, // Answer at the slowest legal time
  output logic dout_o, // Read data pin
  output logic viol_o // Write timing broken by the controller
);
  logic mem [0:65535]; // No contents set at power-up
  realtime t_fall = 0.0;
  realtime t_din = 0.0;
  initial dout_o = 1'b0;
  initial viol_o = 1'b0;
  always @(din_i) t_din = $realtime;
  always @(negedge wstb_n_i) t_fall = $realtime;
  // Store at whichever control rises first while both are low
  always @(posedge wstb_n_i or posedge sel_n_i) begin
    if (sel_n_i ^ wstb_n_i) begin
      mem[addr_i] = din_i;
      if ($realtime - t_fall < 6.0 || $realtime - t_din < 5.0) viol_o = 1'b1;
    end
  end
  // Drive only in a read; release is quicker than drive
  always @(addr_i or sel_n_i or wstb_n_i) begin
    if (!sel_n_i && wstb_n_i)
      dout_o <= #(slow_i ? 9.0 : 3.0) mem[addr_i];
    else
      dout_o <= #1.0 ~dout_o;
  end
endmodule : asram_mem_model
`default_nettype wire

// ### asram_ctl_tb.sv
// Purpose: Self-checking bench for the asynchronous memory controller.
// Assumes: 200 MHz clock; memory model on the pin side.
// Notes: Stored bits are tracked in an associative array.
`timescale 1ns/1ps
`default_nettype none
module asram_ctl_tb;
  logic clock_i = 1'b0, srst_i = 1'b1, req_i = 1'b0, we_i = 1'b0;
  logic wdata_i = 1'b0, retain_i = 1'b0, slow = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] mem_addr_o;
  logic ready_o, rvalid_o, rdata_o, done_o, retained_o;
  logic mem_din_o, mem_sel_n_o, mem_wstb_n_o, mem_dout_i, viol;
  int fail_count = 0, comparisons = 0, cycles = 0, seed = 20;
  bit ref_mem [int];
  logic [15:0] a;
  always #2.5 clock_i = ~clock_i;
  asram_ctl dut (.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i), .we_i(we_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .retain_i(retain_i), .ready_o(ready_o),
    .rvalid_o(rvalid_o), .rdata_o(rdata_o), .done_o(done_o), .retained_o(retained_o),
    .mem_addr_o(mem_addr_o), .mem_din_o(mem_din_o), .mem_sel_n_o(mem_sel_n_o),
    .mem_wstb_n_o(mem_wstb_n_o), .mem_dout_i(mem_dout_i));
  asram_mem_model mem (.addr_i(mem_addr_o), .din_i(mem_din_o), .sel_n_i(mem_sel_n_o),
    .wstb_n_i(mem_wstb_n_o), .slow_i(slow), .dout_o(mem_dout_i), .viol_o(viol));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // ----------------------------------------
  // One access: request, wait for take, then time the answer
  // ----------------------------------------
  task automatic access(input logic we, input logic [15:0] ad, input logic d);
    int n;
    logic exp;
    n = 0;
    exp = ref_mem.exists(ad) ? ref_mem[ad] : 1'b0;
    @(posedge clock_i);
    req_i <= 1'b1;
    we_i <= we;
    addr_i <= ad;
    wdata_i <= d;
    do @(negedge clock_i); while (ready_o !== 1'b1 && ++n < 20);
    @(posedge clock_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (done_o !== 1'b1 && n < 20);
    check(16'(n), we ? 16'h0004 : 16'h0005);
    check({15'h0000, rvalid_o}, {15'h0000, !we});
    if (we) ref_mem[ad] = d;
    else check({15'h0000, rdata_o}, {15'h0000, exp});
  endtask : access
  initial begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    access(1'b1, 16'h0000, 1'b1);
    access(1'b1, 16'hFFFF, 1'b0);
    access(1'b0, 16'h0000, 1'b0);
    access(1'b0, 16'h0000, 1'b0);
    access(1'b0, 16'hFFFF, 1'b0);
    for (int i = 0; i < 40; i++) begin
      a = 16'($random(seed));
      slow <= a[3];
      access(1'b1, a, a[7]);
      access(1'b0, a, 1'b0);
    end
    @(posedge clock_i);
    retain_i <= 1'b1;
    req_i <= 1'b1;
    repeat (3) @(negedge clock_i);
    check({14'h0000, retained_o, mem_sel_n_o}, 16'h0003);
    check({15'h0000, ready_o}, 16'h0000);
    @(posedge clock_i);
    retain_i <= 1'b0;
    req_i <= 1'b0;
    repeat (2) @(negedge clock_i);
    check({14'h0000, retained_o, mem_sel_n_o}, 16'h0001);
    access(1'b0, 16'h0000, 1'b0);
    check({15'h0000, viol}, 16'h0000);
    end_sim();
  end
endmodule : asram_ctl_tb
`default_nettype wire
